// file: logic/fiap_pkg.sv
// Package of register map, field layout, key pattern and timing for the flash erase/write sequencer
// Behaviour
// - A correct unlock sets the enable flag; erase and write run only while it is high
// - Unlock: software writes mode 110, then sets the unlock trigger bit
// - Setting the trigger bit starts a timer bounding the key acceptance window
// - Timer expiry clears the trigger bit whatever keys were written
// - Any wrong key leaves erase/write disabled; the whole unlock must be repeated
// - Software clearing the enable flag disables erase and write at once
// - In erase mode each word 0 high write tags the address, then increments, saturating
// - Only tagged addresses are erased
// - Erase: mode 001, buffer clear, write start; device erases tagged page, drops start
// - Write buffer holds 32 words, one page, selected by address bits 12 to 5
// - Each data load increments the buffer address, stopping at the page's last word
// - Mode 000 with write start programs the buffer; device drops the start bit
// - The CPU is stalled while erase or write runs
// - Start bit high time depends on the program-time select bit
// - Select 0: erase 3.2 ms, write 2.2 ms; select 1: erase 3.7 ms, write 3.0 ms
// - Word 0 high write loads the 16-bit word and increments the address; low only stores
// - Hardware clears start and buffer-clear bits when their operation completes
package fiap_pkg;

  // Register byte addresses
  localparam logic [5:0] OFS_CTRL_ZERO = 6'h00;
  localparam logic [5:0] OFS_CTRL_TWO  = 6'h04;
  localparam logic [5:0] OFS_ADDR_LOW  = 6'h08;
  localparam logic [5:0] OFS_ADDR_HIGH = 6'h0c;
  localparam logic [5:0] OFS_WORD_LOW  = 6'h10; // Word n low at 0x10 + 8n
  localparam logic [5:0] OFS_WORD_HIGH = 6'h14; // Word n high at 0x14 + 8n
  localparam logic [5:0] OFS_WORD_END  = 6'h2c; // Word 3 high, last mapped data register

  // Control zero fields
  localparam int CZ_EN_BIT    = 7;
  localparam int CZ_MODE_LSB  = 4;
  localparam int CZ_TRIG_BIT  = 3;
  localparam int CZ_START_BIT = 2;
  // Control two fields
  localparam int CT_PTS_BIT   = 1;
  localparam int CT_CLR_BIT   = 0;

  localparam logic [7:0]  BYTE_RESET = 8'h00;
  localparam logic [12:0] ADDR_RESET = 13'h0000;

  typedef enum logic [2:0]
  {
    FIAP_MODE_WRITE  = 3'h0,
    FIAP_MODE_ERASE  = 3'h1,
    FIAP_MODE_UNLOCK = 3'h6
  } fiap_mode_type;

  // Op sequencer, Gray along idle -> stream -> time; time -> idle flips both bits
  typedef enum logic [1:0]
  {
    FIAP_IDLE   = 2'h0,
    FIAP_STREAM = 2'h1,
    FIAP_TIME   = 2'h3
  } fiap_state_type;

  localparam int          PAGE_WORDS = 32;
  localparam logic [4:0]  LAST_WORD  = 5'h1f;
  localparam logic [2:0]  KEY_COUNT  = 3'h6;

  // Timing: clock period, operation times and unlock window in ns; unlock window also in cycles
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned ERASE_SHORT_NS  = 3200000;
  localparam int unsigned WRITE_SHORT_NS  = 2200000;
  localparam int unsigned ERASE_LONG_NS   = 3700000;
  localparam int unsigned WRITE_LONG_NS   = 3000000;
  localparam int unsigned UNLOCK_WIN_NS   = 51200;
  localparam int unsigned UNLOCK_WIN_CYC  = UNLOCK_WIN_NS / CLK_PERIOD_NS;

  // Expected register and byte for each key step
  function automatic logic [13:0] key_step(input logic [2:0] pos);
    case (pos)
      3'h0:    key_step = {6'h18, 8'h00};
      3'h1:    key_step = {6'h20, 8'h0d};
      3'h2:    key_step = {6'h28, 8'hc3};
      3'h3:    key_step = {6'h1c, 8'h04};
      3'h4:    key_step = {6'h24, 8'h09};
      default: key_step = {6'h2c, 8'h40};
    endcase
  endfunction

endpackage

// file: logic/fiap_buf_if.sv
// Interface between the sequencer and its write buffer memory
`timescale 1ns/1ps
interface fiap_buf_if;
  logic        we;
  logic [4:0]  waddr;
  logic [15:0] wdata;
  logic [4:0]  raddr;
  logic [15:0] rdata;
  modport source (output we, output waddr, output wdata, output raddr, input rdata);
  modport sink   (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

// file: logic/fiap_wbuf.sv
// 32-word page write buffer with registered read data
`timescale 1ns/1ps
module fiap_wbuf
(
  input  wire logic    clk,
  fiap_buf_if.sink     bus
);
  logic [15:0] mem [0:31];
  logic [15:0] rdata_ff;

  // Write port and registered read port
  always_ff @(posedge clk)
  begin
    if (bus.we)
      mem[bus.waddr] <= bus.wdata;
    rdata_ff <= mem[bus.raddr];
  end

  assign bus.rdata = rdata_ff;
endmodule

// file: logic/fiap_ctrl.sv
// Flash erase/write sequencer with Avalon-MM register slave
//
// Implementation choices: the Avalon-MM register port and the register offsets.
`timescale 1ns/1ps
module fiap_ctrl
#(
  parameter int unsigned ERASE_SHORT_CYC = fiap_pkg::ERASE_SHORT_NS / fiap_pkg::CLK_PERIOD_NS,
  parameter int unsigned WRITE_SHORT_CYC = fiap_pkg::WRITE_SHORT_NS / fiap_pkg::CLK_PERIOD_NS,
  parameter int unsigned ERASE_LONG_CYC  = fiap_pkg::ERASE_LONG_NS / fiap_pkg::CLK_PERIOD_NS,
  parameter int unsigned WRITE_LONG_CYC  = fiap_pkg::WRITE_LONG_NS / fiap_pkg::CLK_PERIOD_NS
)
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output wire logic [31:0] avs_readdata,
  output wire logic        avs_waitrequest,
  output wire logic        cpu_stall,
  output wire logic        flash_erase,
  output wire logic [7:0]  flash_erase_page,
  output wire logic [31:0] flash_erase_tags,
  output wire logic        flash_prog_we,
  output wire logic [12:0] flash_prog_addr,
  output wire logic [15:0] flash_prog_data
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0]           mode;
    logic                 trig;
    logic                 start;
    logic                 en;
    logic                 pts;
    logic                 clr;
    logic [12:0]          addr;
    logic [3:0][7:0]      d_lo;
    logic [3:0][7:0]      d_hi;
    logic [31:0]          valid;
    logic [31:0]          tags;
    logic [2:0]           key_pos;
    logic                 key_bad;
    logic [10:0]          utmr;
    fiap_pkg::fiap_state_type st;
    logic                 op_erase;
    logic [5:0]           idx;
    logic [16:0]          cnt;
    logic                 wait_n;
    logic [31:0]          rdata;
    logic                 fl_erase;
    logic [31:0]          fl_tags;
    logic                 fl_we;
    logic [12:0]          fl_addr;
    logic [15:0]          fl_data;
    logic                 stall;
  } fiap_regs_type;

  fiap_regs_type s_ff;
  fiap_regs_type nxt_s;

  fiap_buf_if buf_if ();

  fiap_wbuf u_wbuf
  (
    .clk (clk),
    .bus (buf_if)
  );

  logic        acc;
  logic        wr_acc;
  logic [7:0]  wbyte;
  logic [13:0] kexp;
  logic [2:0]  wmode;

  // Data word registers only; anything above word 3 high is unmapped so it cannot alias word 0 or 1
  function automatic logic word_reg(input logic [5:0] a);
    word_reg = a >= fiap_pkg::OFS_WORD_LOW && a <= fiap_pkg::OFS_WORD_END && a[1:0] == 2'h0;
  endfunction

  // Cycle counts for the operation timer, chosen by program-time select, and for the unlock window timer
  localparam logic [16:0] ERASE_S = 17'(ERASE_SHORT_CYC - 1);
  localparam logic [16:0] WRITE_S = 17'(WRITE_SHORT_CYC - 1);
  localparam logic [16:0] ERASE_L = 17'(ERASE_LONG_CYC - 1);
  localparam logic [16:0] WRITE_L = 17'(WRITE_LONG_CYC - 1);
  localparam logic [10:0] UWIN    = 11'(fiap_pkg::UNLOCK_WIN_CYC - 1);

  // Bus access decode; one access taken at the edge where waitrequest is low
  assign acc    = (avs_read | avs_write) & ~s_ff.wait_n;
  assign wr_acc = acc & avs_write & avs_byteenable[0];
  assign wbyte  = avs_writedata[7:0];
  assign kexp   = fiap_pkg::key_step(s_ff.key_pos);
  assign wmode  = wbyte[fiap_pkg::CZ_MODE_LSB +: 3];

  // Buffer read address follows the stream index during a write
  assign buf_if.raddr = s_ff.idx[4:0];

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    nxt_s          = s_ff;
    nxt_s.fl_erase = 1'b0;
    nxt_s.fl_we    = 1'b0;
    buf_if.we      = 1'b0;
    buf_if.waddr   = s_ff.addr[4:0];
    buf_if.wdata   = {s_ff.d_hi[0], s_ff.d_lo[0]};

    // Waitrequest drops one cycle after a request; held high while an op stalls the CPU
    nxt_s.wait_n = ~((avs_read | avs_write) & s_ff.wait_n & (s_ff.st == fiap_pkg::FIAP_IDLE));

    // Read mux, loaded in the cycle waitrequest drops so data stand at the taking edge
    nxt_s.rdata = 32'h0000_0000;
    if (avs_read)
    begin
      case (avs_address)
        fiap_pkg::OFS_CTRL_ZERO: nxt_s.rdata[7:0] = {s_ff.en, s_ff.mode, s_ff.trig, s_ff.start, 2'h0};
        fiap_pkg::OFS_CTRL_TWO:  nxt_s.rdata[7:0] = {6'h00, s_ff.pts, s_ff.clr};
        fiap_pkg::OFS_ADDR_LOW:  nxt_s.rdata[7:0] = s_ff.addr[7:0];
        fiap_pkg::OFS_ADDR_HIGH: nxt_s.rdata[7:0] = {3'h0, s_ff.addr[12:8]};
        default:
        begin
          if (word_reg(avs_address))
            nxt_s.rdata[7:0] = avs_address[2] ? s_ff.d_hi[avs_address[4:3] - 2'h2]
                                               : s_ff.d_lo[avs_address[4:3] - 2'h2];
        end
      endcase
    end

    // Unlock window timer; expiry drops the trigger regardless of keys
    if (s_ff.trig)
    begin
      if (s_ff.utmr == 11'h000)
        nxt_s.trig = 1'b0;
      else
        nxt_s.utmr = s_ff.utmr - 11'h001;
    end

    // Buffer clear completes in one cycle
    if (s_ff.clr)
    begin
      nxt_s.valid     = 32'h0000_0000;
      nxt_s.addr[4:0] = 5'h00;
      nxt_s.clr       = 1'b0;
    end

    // Register writes
    if (wr_acc)
    begin
      case (avs_address)
        fiap_pkg::OFS_CTRL_ZERO:
        begin
          nxt_s.mode = wmode;
          if (!wbyte[fiap_pkg::CZ_EN_BIT])
            nxt_s.en = 1'b0;
          // Trigger arms only with unlock mode written; restarts the key sequence
          if (wbyte[fiap_pkg::CZ_TRIG_BIT] && wmode == fiap_pkg::FIAP_MODE_UNLOCK)
          begin
            nxt_s.trig    = 1'b1;
            nxt_s.utmr    = UWIN;
            nxt_s.key_pos = 3'h0;
            nxt_s.key_bad = 1'b0;
          end
          // Start is taken only when enabled and an erase or write mode is selected
          if (wbyte[fiap_pkg::CZ_START_BIT] && s_ff.en && wbyte[fiap_pkg::CZ_EN_BIT]
              && (wmode == fiap_pkg::FIAP_MODE_ERASE || wmode == fiap_pkg::FIAP_MODE_WRITE))
          begin
            nxt_s.start    = 1'b1;
            nxt_s.stall    = 1'b1;
            nxt_s.op_erase = (wmode == fiap_pkg::FIAP_MODE_ERASE);
            nxt_s.idx      = 6'h00;
            if (wmode == fiap_pkg::FIAP_MODE_ERASE)
            begin
              nxt_s.st       = fiap_pkg::FIAP_TIME;
              nxt_s.fl_erase = 1'b1;
              nxt_s.fl_tags  = s_ff.tags;
              nxt_s.cnt      = s_ff.pts ? ERASE_L : ERASE_S;
            end
            else
              nxt_s.st = fiap_pkg::FIAP_STREAM;
          end
        end
        fiap_pkg::OFS_CTRL_TWO:
        begin
          nxt_s.pts = wbyte[fiap_pkg::CT_PTS_BIT];
          if (wbyte[fiap_pkg::CT_CLR_BIT])
            nxt_s.clr = 1'b1;
        end
        fiap_pkg::OFS_ADDR_LOW:  nxt_s.addr[7:0]  = wbyte;
        fiap_pkg::OFS_ADDR_HIGH: nxt_s.addr[12:8] = wbyte[4:0];
        default:
        begin
          if (word_reg(avs_address))
          begin
            if (avs_address[2])
              nxt_s.d_hi[avs_address[4:3] - 2'h2] = wbyte;
            else
              nxt_s.d_lo[avs_address[4:3] - 2'h2] = wbyte;
            // Key steps: words 1-3, in order; a wrong register or byte spoils the attempt
            if (s_ff.trig && avs_address != fiap_pkg::OFS_WORD_LOW && avs_address != fiap_pkg::OFS_WORD_HIGH
                && s_ff.key_pos != fiap_pkg::KEY_COUNT)
            begin
              if (avs_address != kexp[13:8] || wbyte != kexp[7:0])
                nxt_s.key_bad = 1'b1;
              nxt_s.key_pos = s_ff.key_pos + 3'h1;
              if (s_ff.key_pos == 3'h5 && !s_ff.key_bad && avs_address == kexp[13:8] && wbyte == kexp[7:0])
                nxt_s.en = 1'b1;
            end
            // Word 0 high: load buffer word (or tag in erase mode), step address within page
            if (avs_address == fiap_pkg::OFS_WORD_HIGH)
            begin
              if (s_ff.mode == fiap_pkg::FIAP_MODE_ERASE)
                nxt_s.tags[s_ff.addr[4:0]] = 1'b1;
              else
              begin
                buf_if.we                   = 1'b1;
                buf_if.wdata                = {wbyte, s_ff.d_lo[0]};
                nxt_s.valid[s_ff.addr[4:0]] = 1'b1;
              end
              if (s_ff.addr[4:0] != fiap_pkg::LAST_WORD)
                nxt_s.addr[4:0] = s_ff.addr[4:0] + 5'h01;
            end
          end
        end
      endcase
    end

    // Operation sequencer
    case (s_ff.st)
      fiap_pkg::FIAP_IDLE:
      begin
      end
      fiap_pkg::FIAP_STREAM:
      begin
        // Buffer data arrive a cycle after the read address; emit word idx-1
        if (s_ff.idx != 6'h00)
        begin
          nxt_s.fl_we   = s_ff.valid[s_ff.idx[4:0] - 5'h01];
          nxt_s.fl_addr = {s_ff.addr[12:5], s_ff.idx[4:0] - 5'h01};
          nxt_s.fl_data = buf_if.rdata;
        end
        if (s_ff.idx == 6'(fiap_pkg::PAGE_WORDS))
        begin
          nxt_s.st  = fiap_pkg::FIAP_TIME;
          nxt_s.cnt = s_ff.pts ? WRITE_L : WRITE_S;
        end
        else
          nxt_s.idx = s_ff.idx + 6'h01;
      end
      fiap_pkg::FIAP_TIME:
      begin
        if (s_ff.cnt == 17'h00000)
        begin
          nxt_s.st    = fiap_pkg::FIAP_IDLE;
          nxt_s.start = 1'b0;
          nxt_s.stall = 1'b0;
          if (s_ff.op_erase)
            nxt_s.tags = 32'h0000_0000;
        end
        else
          nxt_s.cnt = s_ff.cnt - 17'h00001;
      end
      default: nxt_s.st = fiap_pkg::FIAP_IDLE;
    endcase
  end

  // ==========================================================
  // State register
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      s_ff          <= '0;
      s_ff.addr     <= fiap_pkg::ADDR_RESET;
      s_ff.st       <= fiap_pkg::FIAP_IDLE;
      s_ff.wait_n   <= 1'b1; // Idle waitrequest high, a request is answered next cycle
    end
    else
      s_ff <= nxt_s;
  end

  // Outputs straight from the state register
  assign avs_readdata     = s_ff.rdata;
  assign avs_waitrequest  = s_ff.wait_n;
  assign cpu_stall        = s_ff.stall;
  assign flash_erase      = s_ff.fl_erase;
  assign flash_erase_page = s_ff.addr[12:5];
  assign flash_erase_tags = s_ff.fl_tags;
  assign flash_prog_we    = s_ff.fl_we;
  assign flash_prog_addr  = s_ff.fl_addr;
  assign flash_prog_data  = s_ff.fl_data;

endmodule

// file: testbench/fiap_props.sv
// Checker of bus, stall and flash strobe timing of the flash erase/write sequencer
`timescale 1ns/1ps
module fiap_props
#(
  parameter int unsigned ERASE_SHORT_CYC = 20,
  parameter int unsigned WRITE_SHORT_CYC = 10,
  parameter int unsigned ERASE_LONG_CYC  = 30,
  parameter int unsigned WRITE_LONG_CYC  = 15
)
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        cpu_stall,
  input wire logic        flash_erase,
  input wire logic [7:0]  flash_erase_page,
  input wire logic [31:0] flash_erase_tags,
  input wire logic        flash_prog_we,
  input wire logic [12:0] flash_prog_addr,
  input wire logic [15:0] flash_prog_data
);
  // Slack above the timers covers the write stream phase
  localparam int unsigned STALL_MAX = ERASE_LONG_CYC + WRITE_LONG_CYC + 40;

  // ==========================================================
  // Stall length counter
  logic [31:0] stall_cnt_ff;
  logic [31:0] nxt_stall_cnt;
  assign nxt_stall_cnt = cpu_stall ? stall_cnt_ff + 32'h1 : 32'h0;
  always_ff @(posedge clk)
    stall_cnt_ff <= rst ? 32'h0 : nxt_stall_cnt;

  // ==========================================================
  // Operation kind and time select, followed from the bus and the strobes
  logic        pts_ff;
  logic        erase_ff;
  logic [31:0] op_len;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pts_ff   <= 1'b0;
      erase_ff <= 1'b0;
    end
    else
    begin
      if (avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address == fiap_pkg::OFS_CTRL_TWO)
        pts_ff <= avs_writedata[fiap_pkg::CT_PTS_BIT];
      if (flash_erase)
        erase_ff <= 1'b1;
      else if (!cpu_stall)
        erase_ff <= 1'b0;
    end
  end

  // A write streams one page plus one cycle of read latency before its timer runs
  assign op_len = erase_ff ? (pts_ff ? ERASE_LONG_CYC : ERASE_SHORT_CYC)
                           : fiap_pkg::PAGE_WORDS + 1 + (pts_ff ? WRITE_LONG_CYC : WRITE_SHORT_CYC);

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  reset_quiet_a: assert property (disable iff (1'b0) rst |=> avs_waitrequest && !cpu_stall && !flash_prog_we)
    else $error("outputs not quiet after reset");
  wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  stall_bus_a: assert property (cpu_stall |-> avs_waitrequest)
    else $error("bus answered while cpu stalled");
  erase_pulse_a: assert property (flash_erase |=> !flash_erase)
    else $error("erase strobe longer than one cycle");
  erase_stall_a: assert property (flash_erase |-> cpu_stall)
    else $error("erase strobe without stall");
  idle_quiet_a: assert property (!cpu_stall |-> !flash_erase && !flash_prog_we)
    else $error("flash strobe outside an operation");
  prog_page_a: assert property (flash_prog_we && $past(flash_prog_we) |->
    flash_prog_addr[12:5] == $past(flash_prog_addr[12:5]) && flash_prog_addr > $past(flash_prog_addr))
    else $error("program words leave page or go backwards");
  stall_len_a: assert property ($fell(cpu_stall) |-> stall_cnt_ff == op_len)
    else $error("operation length does not match the selected time");
  stall_bound_a: assert property (cpu_stall |-> stall_cnt_ff < STALL_MAX)
    else $error("operation runs too long");
endmodule

bind fiap_ctrl fiap_props #(.ERASE_SHORT_CYC(ERASE_SHORT_CYC), .WRITE_SHORT_CYC(WRITE_SHORT_CYC),
  .ERASE_LONG_CYC(ERASE_LONG_CYC), .WRITE_LONG_CYC(WRITE_LONG_CYC)) i_fiap_props (.clk(clk), .rst(rst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .cpu_stall(cpu_stall), .flash_erase(flash_erase), .flash_erase_page(flash_erase_page),
  .flash_erase_tags(flash_erase_tags), .flash_prog_we(flash_prog_we), .flash_prog_addr(flash_prog_addr),
  .flash_prog_data(flash_prog_data));

// file: testbench/tb.sv
// Self-checking bench of the flash erase/write sequencer
`timescale 1ns/1ps
module tb;
  logic        clk, rst, avs_read, avs_write, avs_waitrequest, cpu_stall, flash_erase, flash_prog_we;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, flash_erase_tags;
  logic [3:0]  avs_byteenable;
  logic [7:0]  flash_erase_page;
  logic [12:0] flash_prog_addr;
  logic [15:0] flash_prog_data;
  logic [63:0] rd_q[$], fl_q[$];
  logic [63:0] re, fe;
  logic [15:0] wd[5];
  int          errors, checks_done;

  // Short timer values keep the run brief
  fiap_ctrl #(.ERASE_SHORT_CYC(20), .WRITE_SHORT_CYC(10), .ERASE_LONG_CYC(30), .WRITE_LONG_CYC(15)) i_fiap_ctrl
  (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cpu_stall(cpu_stall), .flash_erase(flash_erase),
    .flash_erase_page(flash_erase_page), .flash_erase_tags(flash_erase_tags), .flash_prog_we(flash_prog_we),
    .flash_prog_addr(flash_prog_addr), .flash_prog_data(flash_prog_data)
  );

  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // ==========================================================
  // Compare tasks and verdict
  task automatic cmp_read(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] mask);
    checks_done++;
    if ((got & mask) !== (exp & mask))
    begin
      errors++;
      $display("ERROR %0t read got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic cmp_flash(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t flash got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    // Notes left over mean an expected result never showed
    if (rd_q.size() + fl_q.size() != 0)
      errors++;
    if (errors == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // Monitor: each result takes the oldest note of its kind
  always @(posedge clk)
  begin
    if (!rst && avs_read && !avs_waitrequest)
    begin
      re = (rd_q.size() != 0) ? rd_q.pop_front() : '1;
      cmp_read(avs_readdata, re[31:0], re[63:32]);
    end
    if (!rst && (flash_prog_we || flash_erase))
    begin
      fe = (fl_q.size() != 0) ? fl_q.pop_front() : '1;
      if (flash_erase)
        cmp_flash({24'h000001, flash_erase_page, flash_erase_tags}, fe);
      else
        cmp_flash({35'h0, flash_prog_addr, flash_prog_data}, fe);
    end
  end

  // ==========================================================
  // Avalon master: hold the request until waitrequest is seen low
  task automatic bus(input logic [5:0] a, input logic w, input logic [7:0] d, input logic [3:0] be);
    @(posedge clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h0, d};
    avs_byteenable <= be;
    // Only the watchdog ends a wait that never sees waitrequest low
    do
      @(posedge clk);
    while (avs_waitrequest !== 1'b0);
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    bus(a, 1'b1, d, 4'hf);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e, input logic [7:0] m);
    rd_q.push_back({24'hffffff, m, 24'h0, e});
    bus(a, 1'b0, 8'h00, 4'hf);
  endtask

  // Key sequence; flip spoils the third byte
  task automatic unlock(input logic [7:0] flip);
    logic [5:0] ka[6];
    logic [7:0] kd[6];
    ka = '{6'h18, 6'h20, 6'h28, 6'h1c, 6'h24, 6'h2c};
    kd = '{8'h00, 8'h0d, 8'hc3, 8'h04, 8'h09, 8'h40};
    wr(6'h00, 8'h68);
    for (int i = 0; i < 6; i++)
      wr(ka[i], (i == 2) ? kd[i] ^ flip : kd[i]);
  endtask

  // Watchdog: the sequence needs well under 3000 cycles
  initial
  begin
    #400000;
    errors++;
    end_of_test();
  end

  // ==========================================================
  // Main sequence
  initial
  begin
    void'($urandom(32'he3970ca6));
    rst = 1'b1;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'h0;
    errors = 0;
    checks_done = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd(6'h00, 8'h00, 8'hff);
    rd(6'h04, 8'h00, 8'hff);
    rd(6'h2c, 8'h00, 8'hff);
    bus(6'h08, 1'b1, 8'h55, 4'h0);
    rd(6'h08, 8'h00, 8'hff);
    wr(6'h3c, 8'h77);
    rd(6'h3c, 8'h00, 8'hff);
    unlock(8'h01);
    rd(6'h00, 8'h00, 8'h80);
    repeat (1030) @(posedge clk);
    rd(6'h00, 8'h60, 8'hff);
    unlock(8'h00);
    rd(6'h00, 8'h80, 8'h80);
    // Erase: tag words 30 and 31 of page 9, third tag saturates
    wr(6'h00, 8'h90);
    wr(6'h08, 8'h3e);
    wr(6'h0c, 8'h01);
    repeat (3) wr(6'h14, 8'h00);
    rd(6'h08, 8'h3f, 8'hff);
    wr(6'h04, 8'h01);
    rd(6'h04, 8'h00, 8'h01);
    fl_q.push_back({24'h000001, 8'h09, 32'hc0000000});
    wr(6'h00, 8'h94);
    rd(6'h00, 8'h80, 8'h84);
    // Write five words from word 28; the fifth overwrites the last word
    wr(6'h00, 8'h80);
    wr(6'h04, 8'h01);
    wr(6'h08, 8'h3c);
    for (int i = 0; i < 5; i++)
    begin
      wd[i] = 16'($urandom());
      wr(6'h10, wd[i][7:0]);
      wr(6'h14, wd[i][15:8]);
    end
    rd(6'h08, 8'h3f, 8'hff);
    for (int i = 0; i < 4; i++)
      fl_q.push_back({35'h0, 13'h13c + 13'(i), wd[(i == 3) ? 4 : i]});
    wr(6'h04, 8'h02);
    wr(6'h00, 8'h84);
    rd(6'h00, 8'h80, 8'h84);
    // Rewrite after a failed verify: cleared buffer holds only the one reloaded word
    wr(6'h04, 8'h03);
    wr(6'h08, 8'h3d);
    wd[0] = 16'($urandom());
    wr(6'h10, wd[0][7:0]);
    wr(6'h14, wd[0][15:8]);
    fl_q.push_back({35'h0, 13'h13d, wd[0]});
    wr(6'h00, 8'h84);
    rd(6'h00, 8'h80, 8'h84);
    // Disable, then a start must be ignored
    wr(6'h00, 8'h00);
    rd(6'h00, 8'h00, 8'h80);
    wr(6'h00, 8'h84);
    rd(6'h00, 8'h00, 8'h84);
    repeat (60) @(posedge clk);
    end_of_test();
  end
endmodule
